// ### design/hmap_port.sv
// Host memory access port: pin sequencing, overlay register and memories.
`timescale 1ns/1ns
`default_nettype none
module hmap_port
  import hmap_pkg::*;
#(
  parameter int PM_WORDS = PM_DEPTH, // Program memory depth.
  parameter int DM_WORDS = DM_DEPTH // Data memory depth.
) (
  input wire logic clk, // Processor clock, 50 MHz.
  input wire logic sys_rst, // Asynchronous reset, active high.
  input wire logic port_select_n, // Port select from host, low active.
  input wire logic port_read_strobe_n, // Read strobe, low active.
  input wire logic port_write_strobe_n, // Write strobe, low active.
  input wire logic port_address_latch, // Address latch, high active.
  input wire logic [15:0] port_addr_data_bus_i, // Shared bus, pin level.
  output logic [15:0] port_addr_data_bus_o, // Shared bus, driven word.
  output logic port_addr_data_bus_oe, // Shared bus drive enable.
  output logic port_acknowledge_n, // Acknowledge, low when ready.
  input wire logic core_ovl_wr, // Core write strobe for overlay register.
  input wire logic [15:0] core_ovl_wdata, // Core write data.
  output logic [15:0] core_ovl_rdata, // Overlay register contents.
  output logic short_read_only, // Short-read-only mode in force.
  output logic last_write_long // Last host write was a long write.
);
  // Whole sequencer state in one record.
  typedef struct packed {
    logic [19:0] sync1; // First synchroniser stage of the pins.
    logic [19:0] sync2; // Second synchroniser stage of the pins.
    hmap_state_e st; // Sequencer state.
    logic [3:0] cnt; // Cycle counter within a state.
    logic [13:0] addr; // Latched word address.
    logic dm; // Latched memory select.
    logic pm_half; // Next program access is the second half.
    logic [15:0] pm_stash; // Upper part of a program write.
    logic [7:0] pm_low; // Low byte of the last program read.
    logic [15:0] prev; // Word fetched by the previous read.
    logic [15:0] out_word; // Word on the shared bus.
    logic oe; // Bus drive enable.
    logic ack_n; // Acknowledge pin.
    logic wr_done; // Current write already committed.
    logic wr_long; // Class of the last write.
    logic [15:0] ovl; // Overlay control register.
    logic m_rd; // Memory read request.
    logic m_wr; // Memory write request.
    logic [23:0] m_wdata; // Memory write data.
  } hmap_port_s;

  hmap_port_s r_reg; // Current state.
  hmap_port_s r_next; // Next state.
  hmap_mem_if mif (); // Link to the memories.

  // Synchronised pin views; only the second stage is ever read.
  logic sel_n; // Select after synchronising.
  logic rd_n; // Read strobe after synchronising.
  logic wr_n; // Write strobe after synchronising.
  logic al; // Address latch after synchronising.
  logic [15:0] bus_s; // Bus value after synchronising.
  logic rd_act; // Read cycle in progress.
  logic wr_act; // Write cycle in progress.
  logic is_ovl; // Current address hits the overlay register.
  logic sro; // Short-read-only bit.
  logic [3:0] hold; // Previous-word hold for this read.
  logic [15:0] new_word; // Word produced by this read.

  assign {sel_n, rd_n, wr_n, al, bus_s} = r_reg.sync2;
  assign rd_act = !sel_n && !rd_n;
  assign wr_act = !sel_n && !wr_n;
  assign is_ovl = r_reg.dm && (r_reg.addr == OVL_ADDR);
  assign sro = r_reg.ovl[SRO_BIT];

  // Pick the hold time and the freshly fetched word.
  always_comb begin
    hold = (!r_reg.dm && r_reg.pm_half) ? 4'(HOLD2_CYC) : 4'(HOLD1_CYC);
    if (is_ovl) begin
      new_word = r_reg.ovl;
    end else if (r_reg.dm) begin
      new_word = mif.rdata[15:0];
    end else if (r_reg.pm_half) begin
      new_word = {8'h00, r_reg.pm_low};
    end else begin
      new_word = mif.rdata[23:8];
    end
  end

  // Sequencer. Pins pass two flip-flops first, so every pin reaction lags
  // the pin by about three clocks; that is the price of a safe crossing.
  always_comb begin
    r_next = r_reg;
    r_next.sync1 = {port_select_n, port_read_strobe_n, port_write_strobe_n,
                    port_address_latch, port_addr_data_bus_i};
    r_next.sync2 = r_reg.sync1;
    r_next.m_rd = 1'b0;
    r_next.m_wr = 1'b0;
    // The bus is dropped as soon as the read ends, in any state.
    r_next.oe = r_reg.oe && rd_act;
    // Core write of the overlay register; a host write below overrides.
    if (core_ovl_wr) begin
      r_next.ovl = core_ovl_wdata;
    end
    // Address latch pulse while selected; restarts program halves.
    if (!sel_n && al) begin
      r_next.addr = bus_s[AW-1:0];
      r_next.dm = bus_s[DM_SEL_BIT];
      r_next.pm_half = 1'b0;
    end
    case (r_reg.st)
      ST_IDLE: begin
        // Reads count on the host waiting for a low acknowledge.
        if (rd_act && r_reg.ack_n == 1'b0) begin
          r_next.ack_n = 1'b1;
          r_next.oe = 1'b1;
          r_next.out_word = r_reg.prev;
          r_next.cnt = 4'h0;
          r_next.m_rd = !is_ovl && (r_reg.dm || !r_reg.pm_half);
          r_next.st = ST_RD_HOLD;
        end else if (wr_act) begin
          r_next.ack_n = 1'b1;
          r_next.cnt = 4'h0;
          r_next.wr_done = 1'b0;
          r_next.st = ST_WR;
        end
      end
      ST_RD_HOLD: begin
        // Previous word stays for the hold, then the fetch lands.
        r_next.cnt = r_reg.cnt + 4'h1;
        if (r_reg.cnt + 4'h1 >= hold) begin
          r_next.prev = new_word;
          // Short-read-only keeps the previous word until the read ends.
          if (!sro) begin
            r_next.out_word = new_word;
          end
          if (!r_reg.dm && !r_reg.pm_half) begin
            r_next.pm_low = mif.rdata[7:0];
            r_next.pm_half = 1'b1;
          end else begin
            r_next.pm_half = 1'b0;
            r_next.addr = r_reg.addr + 14'h0001;
          end
          r_next.cnt = 4'h0;
          r_next.st = ST_RD_SETUP;
        end
      end
      ST_RD_SETUP: begin
        // Give the new word its setup before acknowledge falls.
        r_next.cnt = r_reg.cnt + 4'h1;
        if (r_reg.cnt + 4'h1 >= 4'(RD_SETUP_CYC)) begin
          r_next.ack_n = 1'b0;
          r_next.st = ST_DONE;
        end
      end
      ST_WR: begin
        // Acknowledge falls on a fixed delay; the data is taken when the
        // strobe ends, before or after that fall.
        if (r_reg.cnt < 4'(WR_ACK_CYC)) begin
          r_next.cnt = r_reg.cnt + 4'h1;
        end
        if (r_reg.cnt + 4'h1 >= 4'(WR_ACK_CYC) && r_reg.wr_done) begin
          r_next.ack_n = 1'b0;
        end else if (r_reg.cnt + 4'h1 >= 4'(WR_ACK_CYC) && wr_act) begin
          r_next.ack_n = 1'b0;
        end
        if (!wr_act && !r_reg.wr_done) begin
          r_next.wr_done = 1'b1;
          r_next.wr_long = !r_reg.ack_n;
          if (is_ovl) begin
            r_next.ovl = bus_s;
            r_next.addr = r_reg.addr + 14'h0001;
          end else if (r_reg.dm) begin
            r_next.m_wr = 1'b1;
            r_next.m_wdata = {8'h00, bus_s};
            r_next.addr = r_reg.addr + 14'h0001;
          end else if (!r_reg.pm_half) begin
            r_next.pm_stash = bus_s;
            r_next.pm_half = 1'b1;
          end else begin
            r_next.m_wr = 1'b1;
            r_next.m_wdata = {r_reg.pm_stash, bus_s[7:0]};
            r_next.pm_half = 1'b0;
            r_next.addr = r_reg.addr + 14'h0001;
          end
        end
        if (r_reg.wr_done && !r_reg.ack_n) begin
          r_next.st = ST_IDLE;
        end
      end
      ST_DONE: begin
        // Wait for the host to end the cycle before taking another.
        if (!rd_act && !wr_act) begin
          r_next.st = ST_IDLE;
        end
      end
      default: begin
        r_next.st = ST_IDLE;
      end
    endcase
  end

  // State register; acknowledge is low (ready) out of reset.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r_reg <= '0;
      // Idle pin levels: strobes high, address latch low, bus zero.
      r_reg.sync1 <= 20'he0000;
      r_reg.sync2 <= 20'he0000;
      r_reg.st <= ST_IDLE;
      r_reg.ovl <= OVL_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // Memory requests use the address as it stood when issued.
  assign mif.rd = r_reg.m_rd;
  assign mif.wr = r_reg.m_wr;
  assign mif.dm = r_reg.dm;
  assign mif.addr = r_reg.m_wr ? r_reg.addr - 14'h0001 : r_reg.addr;
  assign mif.wdata = r_reg.m_wdata;

  hmap_mem #(
    .PM_WORDS(PM_WORDS),
    .DM_WORDS(DM_WORDS)
  ) u_mem (
    .clk(clk),
    .sys_rst(sys_rst),
    .bus(mif.mem)
  );

  assign port_addr_data_bus_o = r_reg.out_word;
  assign port_addr_data_bus_oe = r_reg.oe;
  assign port_acknowledge_n = r_reg.ack_n;
  assign core_ovl_rdata = r_reg.ovl;
  assign short_read_only = sro;
  assign last_write_long = r_reg.wr_long;
endmodule // hmap_port
`default_nettype wire

// ### design/hmap_pkg.sv
// Shared constants and types for the host memory access port.
package hmap_pkg;
  // Clock period of the processor clock in ns.
  localparam int T_CK_NS = 20;
  // Earliest acknowledge fall after a write starts, in tenths of a period.
  localparam int WR_ACK_MIN_X10 = 15;
  localparam int WR_ACK_CYC =
    (WR_ACK_MIN_X10 * T_CK_NS + 10 * T_CK_NS - 1) / (10 * T_CK_NS);
  // Least setup of new read data before acknowledge falls, in ns.
  localparam int RD_SETUP_NS = T_CK_NS / 2 - 2;
  localparam int RD_SETUP_CYC = (RD_SETUP_NS + T_CK_NS - 1) / T_CK_NS;
  // Least hold of previous data for a data word or first half, in ns.
  localparam int HOLD1_NS = 2 * T_CK_NS - 5;
  localparam int HOLD1_CYC = (HOLD1_NS + T_CK_NS - 1) / T_CK_NS;
  // Least hold of previous data for a second half, in ns.
  localparam int HOLD2_NS = T_CK_NS - 5;
  localparam int HOLD2_CYC = (HOLD2_NS + T_CK_NS - 1) / T_CK_NS;
  // Word widths and address layout of the latched address word.
  localparam int DW = 16;
  localparam int PW = 24;
  localparam int AW = 14;
  localparam int DM_SEL_BIT = 14;
  // Overlay control register location in data memory space.
  localparam logic [13:0] OVL_ADDR = 14'h3fe7;
  localparam int SRO_BIT = 14;
  localparam logic [15:0] OVL_RESET = 16'h0000;
  // Default memory depths in words.
  localparam int PM_DEPTH = 8192;
  localparam int DM_DEPTH = 8192;

  // Port sequencing states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RD_HOLD = 3'b001,
    ST_RD_SETUP = 3'b010,
    ST_WR = 3'b011,
    ST_DONE = 3'b100
  } hmap_state_e;
endpackage

// ### design/hmap_mem_if.sv
// Request and answer signals between the port sequencer and the memories.
`timescale 1ns/1ns
`default_nettype none
interface hmap_mem_if;
  logic rd; // One-cycle read request.
  logic wr; // One-cycle write request.
  logic dm; // High selects data memory, low program memory.
  logic [13:0] addr; // Word address.
  logic [23:0] wdata; // Write data, data memory uses the low 16 bits.
  logic [23:0] rdata; // Read data, valid the cycle after rd.
  modport ctrl (output rd, output wr, output dm, output addr, output wdata,
                input rdata);
  modport mem (input rd, input wr, input dm, input addr, input wdata,
               output rdata);
endinterface
`default_nettype wire

// ### design/hmap_mem.sv
// On-chip program and data memories reached by the host port.
`timescale 1ns/1ns
`default_nettype none
module hmap_mem
  import hmap_pkg::*;
#(
  parameter int PM_WORDS = PM_DEPTH,
  parameter int DM_WORDS = DM_DEPTH
) (
  input wire logic clk, // Processor clock.
  input wire logic sys_rst, // Asynchronous reset, active high.
  hmap_mem_if.mem bus // Requests from the port sequencer.
);
  localparam int PA = $clog2(PM_WORDS);
  localparam int DA = $clog2(DM_WORDS);

  // Registered read word is the only control state here.
  typedef struct packed {
    logic [23:0] rdata;
  } hmap_mem_s;

  hmap_mem_s r_reg; // Current state.
  hmap_mem_s r_next; // Next state.
  logic [PW-1:0] pm_mem [PM_WORDS]; // Program memory words.
  logic [DW-1:0] dm_mem [DM_WORDS]; // Data memory words.

  // A read takes one cycle so the word comes straight from a flip-flop.
  always_comb begin
    r_next = r_reg;
    if (bus.rd) begin
      if (bus.dm) begin
        r_next.rdata = {8'h00, dm_mem[bus.addr[DA-1:0]]};
      end else begin
        r_next.rdata = pm_mem[bus.addr[PA-1:0]];
      end
    end
  end

  // Memory arrays carry no reset, as real RAM would not.
  always_ff @(posedge clk) begin
    if (bus.wr && bus.dm) begin
      dm_mem[bus.addr[DA-1:0]] <= bus.wdata[DW-1:0];
    end
    if (bus.wr && !bus.dm) begin
      pm_mem[bus.addr[PA-1:0]] <= bus.wdata;
    end
  end

  // State register.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign bus.rdata = r_reg.rdata;
endmodule // hmap_mem
`default_nettype wire

// ### sim/hmap_port_assertions.sv
// Checker of the host port pin timing and overlay register.
`timescale 1ns/1ns
`default_nettype none
module hmap_port_assertions
  import hmap_pkg::*;
(
  input wire logic clk, // Clock.
  input wire logic sys_rst, // Reset.
  input wire logic port_select_n, // Select.
  input wire logic port_read_strobe_n, // Read strobe.
  input wire logic port_write_strobe_n, // Write strobe.
  input wire logic port_address_latch, // Latch.
  input wire logic [15:0] port_addr_data_bus_i, // Bus level.
  input wire logic [15:0] port_addr_data_bus_o, // Driven word.
  input wire logic port_addr_data_bus_oe, // Drive enable.
  input wire logic port_acknowledge_n, // Acknowledge.
  input wire logic core_ovl_wr, // Core write.
  input wire logic [15:0] core_ovl_wdata, // Core data.
  input wire logic [15:0] core_ovl_rdata, // Overlay.
  input wire logic short_read_only, // Mode bit.
  input wire logic last_write_long // Write class.
);
  // All checks share the one clock and the one reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // The pins pass a two-flop synchroniser, so reactions take three edges.
  a_read_ack_rise: assert property (
    $fell(port_read_strobe_n) && !port_select_n |->
    ##[1:4] (port_acknowledge_n && port_addr_data_bus_oe))
    else $error("read start not answered");
  a_bus_release: assert property (
    $rose(port_read_strobe_n) && port_addr_data_bus_oe |->
    ##[1:4] !port_addr_data_bus_oe)
    else $error("bus not released");
  a_prev_hold: assert property (
    $rose(port_addr_data_bus_oe) |=> $stable(port_addr_data_bus_o))
    else $error("previous word not held");
  a_data_setup: assert property (
    $fell(port_acknowledge_n) && port_addr_data_bus_oe |->
    $stable(port_addr_data_bus_o))
    else $error("word changed as acknowledge fell");
  a_write_ack_min: assert property (
    $rose(port_acknowledge_n) && !port_addr_data_bus_oe |=>
    port_acknowledge_n)
    else $error("write acknowledge too early");
  a_ack_bounded: assert property (
    $rose(port_acknowledge_n) && !short_read_only |->
    ##[2:8] !port_acknowledge_n)
    else $error("acknowledge stuck high");
  a_reset_clear: assert property (
    $fell(sys_rst) |-> core_ovl_rdata == OVL_RESET && !short_read_only)
    else $error("overlay not clear after reset");
  a_core_write: assert property (
    core_ovl_wr && port_select_n |=>
    core_ovl_rdata == $past(core_ovl_wdata))
    else $error("core write lost");
endmodule // hmap_port_assertions
`default_nettype wire

// ### sim/hmap_host.sv
// Host model driving the port strobes and its side of the bus.
`timescale 1ns/1ns
`default_nettype none
module hmap_host (
  input wire logic clk, // Clock.
  input wire logic port_acknowledge_n, // Device ready when low.
  input wire logic [15:0] port_addr_data_bus_i, // Resolved bus.
  output logic port_select_n, // Select.
  output logic port_read_strobe_n, // Read strobe.
  output logic port_write_strobe_n, // Write strobe.
  output logic port_address_latch, // Latch.
  output logic [15:0] host_dq // Host drive value.
);
  int fails; // Waits that ran out.
  // All strobes idle from time zero.
  initial begin
    {port_select_n, port_read_strobe_n} = 2'b11;
    {port_write_strobe_n, port_address_latch} = 2'b10;
    host_dq = 16'h0000;
    fails = 0;
  end
  // Bounded wait, so a dead device cannot hang the host.
  task automatic wait_ack(input logic lvl);
    int i;
    i = 0;
    while (port_acknowledge_n !== lvl && i < 50) begin
      @(negedge clk);
      i++;
    end
    if (i == 50) fails++;
  endtask
  // Gap after each cycle; released lines flip so no stale word remains.
  task automatic finish_op();
    repeat (3) @(negedge clk);
    host_dq = ~host_dq;
  endtask
  // Address latch pulse with select low.
  task automatic put_addr(input logic [15:0] a);
    wait_ack(1'b0);
    host_dq = a;
    {port_select_n, port_address_latch} = 2'b01;
    repeat (2) @(negedge clk);
    {port_select_n, port_address_latch} = 2'b10;
    finish_op();
  endtask
  // A long write holds the strobe until acknowledge falls.
  task automatic put_word(input logic [15:0] d, input logic long_w);
    wait_ack(1'b0);
    host_dq = d;
    {port_select_n, port_write_strobe_n} = 2'b00;
    if (long_w) begin
      wait_ack(1'b1);
      wait_ack(1'b0);
    end else begin
      repeat (2) @(negedge clk);
    end
    {port_select_n, port_write_strobe_n} = 2'b11;
    finish_op();
  endtask
  // Hold zero waits for acknowledge, else ends after that many cycles.
  task automatic get_word(input int hold, output logic [15:0] w);
    wait_ack(1'b0);
    {port_select_n, port_read_strobe_n} = 2'b00;
    if (hold == 0) begin
      wait_ack(1'b1);
      wait_ack(1'b0);
    end else begin
      repeat (hold) @(negedge clk);
    end
    w = port_addr_data_bus_i;
    {port_select_n, port_read_strobe_n} = 2'b11;
    finish_op();
  endtask
endmodule // hmap_host
`default_nettype wire

// ### sim/tb.sv
// Self-checking bench of the host memory access port.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import hmap_pkg::*;
  logic clk, sys_rst, core_ovl_wr, short_read_only, last_write_long;
  logic port_select_n, port_read_strobe_n, port_write_strobe_n;
  logic port_address_latch, port_addr_data_bus_oe, port_acknowledge_n;
  logic [15:0] port_addr_data_bus_i, port_addr_data_bus_o, host_dq, w;
  logic [15:0] core_ovl_wdata, core_ovl_rdata;
  logic [15:0] mem [8]; // Words written, expected on read.
  logic [13:0] base; // Start address of the run.
  int n_fail, total_checks;
  integer seed;
  hmap_port #(.PM_WORDS(64), .DM_WORDS(64)) hmap_port_inst (.clk,
    .sys_rst, .port_select_n, .port_read_strobe_n, .port_write_strobe_n,
    .port_address_latch, .port_addr_data_bus_i, .port_addr_data_bus_o,
    .port_addr_data_bus_oe, .port_acknowledge_n, .core_ovl_wr,
    .core_ovl_wdata, .core_ovl_rdata, .short_read_only, .last_write_long);
  hmap_host hmap_host_inst (.clk, .port_acknowledge_n,
    .port_addr_data_bus_i, .port_select_n, .port_read_strobe_n,
    .port_write_strobe_n, .port_address_latch, .host_dq);
  // The device wins the wire while it drives; otherwise the host value.
  assign port_addr_data_bus_i =
    port_addr_data_bus_oe ? port_addr_data_bus_o : host_dq;
  // Free-running 50 MHz clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Latched address word for a data memory location.
  function automatic logic [15:0] dm_word(input logic [13:0] a);
    return {2'b01, a};
  endfunction
  // Compares one value and counts it.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Single place where the run ends.
  task automatic report_and_stop();
    n_fail += hmap_host_inst.fails;
    if (n_fail == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    seed = 32'ha24916a9;
    sys_rst = 1'b1;
    core_ovl_wr = 1'b0;
    core_ovl_wdata = 16'h0000;
    n_fail = 0;
    total_checks = 0;
    repeat (12) @(negedge clk);
    chk(core_ovl_rdata, OVL_RESET);
    chk({14'h0, port_acknowledge_n, short_read_only}, 16'h0000);
    sys_rst = 1'b0;
    base = 14'($unsigned($random(seed))) & 14'h0030;
    hmap_host_inst.put_addr(dm_word(base));
    for (int i = 0; i < 8; i++) begin
      mem[i] = 16'($random(seed));
      hmap_host_inst.put_word(mem[i], i != 7);
      if (i == 6) chk(16'(last_write_long), 16'h0001);
    end
    chk(16'(last_write_long), 16'h0000);
    hmap_host_inst.put_addr(dm_word(base));
    for (int i = 0; i < 8; i++) begin
      hmap_host_inst.get_word(0, w);
      chk(w, mem[i]);
    end
    // Host sets the short-read-only bit through the port.
    hmap_host_inst.put_addr(dm_word(OVL_ADDR));
    hmap_host_inst.put_word(16'h4000, 1'b1);
    chk(core_ovl_rdata, 16'h4000);
    chk(16'(short_read_only), 16'h0001);
    // Each read now returns the word fetched by the read before it.
    hmap_host_inst.put_addr(dm_word(base));
    for (int i = 0; i < 9; i++) begin
      hmap_host_inst.get_word(4 + ($unsigned($random(seed)) % 6), w);
      if (i > 0) chk(w, mem[i - 1]);
    end
    // Core clears the bit; ordinary reads work again.
    core_ovl_wdata = 16'($random(seed)) & 16'hbfff;
    core_ovl_wr = 1'b1;
    @(negedge clk);
    core_ovl_wr = 1'b0;
    chk(core_ovl_rdata, core_ovl_wdata);
    hmap_host_inst.put_addr(dm_word(base + 14'h0002));
    hmap_host_inst.get_word(0, w);
    chk(w, mem[2]);
    report_and_stop();
  end
  // Watchdog far beyond the expected run length.
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end
endmodule // tb
bind hmap_port hmap_port_assertions hmap_port_assertions_inst (.clk,
  .sys_rst, .port_select_n, .port_read_strobe_n, .port_write_strobe_n,
  .port_address_latch, .port_addr_data_bus_i, .port_addr_data_bus_o,
  .port_addr_data_bus_oe, .port_acknowledge_n, .core_ovl_wr,
  .core_ovl_wdata, .core_ovl_rdata, .short_read_only, .last_write_long);
`default_nettype wire
